// ---- pmbuv_pkg.sv ----
// Command codes, field layouts, timing constants and state types
package pmbuv_pkg;

  localparam logic [7:0]  CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0]  CMD_UV_ACTION    = 8'h45;
  localparam logic [7:0]  CMD_OC_THRESH    = 8'h46;
  localparam logic [7:0]  CMD_OC_ACTION    = 8'h47;
  localparam logic [7:0]  CMD_STATUS_BYTE  = 8'h78;
  localparam logic [7:0]  CMD_STATUS_WORD  = 8'h79;
  localparam logic [7:0]  CMD_STATUS_VOUT  = 8'h7a;
  localparam logic [7:0]  CMD_STATUS_IOUT  = 8'h7b;

  localparam logic [7:0]  UV_ACTION_VAL    = 8'hba;
  localparam logic [7:0]  OC_ACTION_VAL    = 8'hfa;
  localparam logic [15:0] OC_THRESH_RST    = 16'h0000;

  localparam int SB_OTHER_BIT = 0;
  localparam int SB_OC_BIT    = 4;
  localparam int SW_IOUT_BIT  = 14;
  localparam int SW_VOUT_BIT  = 15;
  localparam int SV_UV_BIT    = 4;
  localparam int SI_OC_BIT    = 7;

  localparam int EXP_MSB  = 15;
  localparam int EXP_LSB  = 11;
  localparam int MANT_MSB = 10;
  localparam int MANT_MAX = 1023;

  localparam int OC_PCT_NUM = 125;
  localparam int OC_PCT_DEN = 100;

  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned RESTART_DELAY_MS = 22;
  localparam int unsigned RESTART_CYCLES   =
    CLK_HZ / 1000 * RESTART_DELAY_MS;
  localparam int          DLY_W            = 21;

  typedef enum logic {PMBUV_RUN, PMBUV_OFF} pmbuv_phase_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  code;
    logic [15:0] data;
  } pmbuv_cmd_t;

  typedef struct packed {
    pmbuv_phase_t      phase;
    logic [DLY_W-1:0]  delayCnt;
    logic              shutDown;
    logic              uvMeta;
    logic              uvSync;
    logic              reqMeta;
    logic              reqSync;
    logic              reqSeen;
    logic              ackTgl;
    logic [15:0]       rspData;
    logic              uvFlag;
    logic              ocFlag;
    logic [15:0]       thresh;
    logic              threshSet;
    logic              alertDrv;
  } pmbuv_core_t;

  typedef struct packed {
    logic        busy;
    logic        reqTgl;
    pmbuv_cmd_t  cmd;
    logic        ackMeta;
    logic        ackSync;
    logic        ackSeen;
    logic        rspValid;
    logic [15:0] rspData;
  } pmbuv_link_t;

endpackage

// ---- pmbuv_fault_ctrl.sv ----
// Undervoltage and overcurrent fault handling with command access
`timescale 1ns/10ps
// Summary of operation
// - Undervoltage fault sets the other summary bit of the status byte.
// - Undervoltage fault sets the output-voltage bit of the status word.
// - Undervoltage fault sets the undervoltage flag in output-voltage status.
// - Undervoltage or overcurrent fault drives the open alert output.
// - Undervoltage fault shuts output at once, restarts after 22 ms.
// - Undervoltage action command is read-only and always reads 0xba.
// - Overcurrent when current exceeds limit; limit defaults to 125% max.
// - Limit word bits 15:11 hold a writable 5-bit signed exponent.
// - Limit word bits 10:0 hold a writable 11-bit signed mantissa.
// - Overcurrent fault sets the overcurrent bit of the status byte.
// - Overcurrent fault sets the output-current bit of the status word.
// - Overcurrent fault sets the overcurrent flag in output-current status.
// - Overcurrent action command is read-only and always reads 0xfa.
// - Overcurrent fault shuts output at once, restarts after 22 ms.
module pmbuv_fault_ctrl
  import pmbuv_pkg::*;
#(
  parameter int unsigned RESTART_CNT = RESTART_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        linkClk,
  input  wire logic        uvDetect,
  input  wire logic [15:0] ioutMeas,
  input  wire logic [15:0] maxCurrentSetting,
  input  wire logic        cmdValid,
  input  wire pmbuv_cmd_t  cmdIn,
  output logic             cmdReady,
  output logic             rspValid,
  output logic [15:0]      rspData,
  output logic             outputEnable,
  output logic             hostAlertOutO,
  output logic             hostAlertOutOe
);

  pmbuv_core_t c_q;
  pmbuv_core_t c_d;
  pmbuv_link_t l_q;
  pmbuv_link_t l_d;

  logic signed [31:0] ocLimit;
  logic [31:0]        dfltLimit;
  logic [15:0]        threshRead;
  logic [7:0]         statusByte;
  logic [15:0]        statusWord;
  logic               exec;
  logic               clearCmd;
  logic               uvTrip;
  logic               ocTrip;

  // Linear format: value = mantissa * 2^exponent, both two's complement
  function automatic logic signed [31:0] lin_decode(input logic [15:0] w);
    logic signed [4:0]  e;
    logic signed [31:0] m;
    e = w[EXP_MSB:EXP_LSB];
    m = 32'(signed'(w[MANT_MSB:0]));
    if (e >= 0)
      lin_decode = m <<< e;
    else
      lin_decode = m >>> (-e);
  endfunction

  function automatic logic [7:0] status_byte_f(input logic uv,
                                               input logic oc);
    status_byte_f = 8'h00;
    status_byte_f[SB_OTHER_BIT] = uv;
    status_byte_f[SB_OC_BIT] = oc;
  endfunction

  // Default limit follows the live max-current setting until written
  assign dfltLimit = 32'(maxCurrentSetting) * OC_PCT_NUM / OC_PCT_DEN;
  assign ocLimit = c_q.threshSet ? lin_decode(c_q.thresh)
                                 : signed'(dfltLimit);
  assign threshRead = c_q.threshSet ? c_q.thresh :
    (dfltLimit > 32'(MANT_MAX)) ? 16'(MANT_MAX) : dfltLimit[15:0];

  assign statusByte = status_byte_f(c_q.uvFlag, c_q.ocFlag);
  always_comb
  begin
    statusWord = {8'h00, statusByte};
    statusWord[SW_VOUT_BIT] = c_q.uvFlag;
    statusWord[SW_IOUT_BIT] = c_q.ocFlag;
  end

  // The link holds its command word still while busy, so the core may read
  // it directly once the request toggle has passed the two-stage sync
  assign exec = c_q.reqSync != c_q.reqSeen;
  assign clearCmd = exec && l_q.cmd.write
                    && l_q.cmd.code == CMD_CLEAR_FAULTS;
  // Faults count only while regulating; a stopped output is low anyway
  assign uvTrip = c_q.phase == PMBUV_RUN && c_q.uvSync;
  assign ocTrip = c_q.phase == PMBUV_RUN
                  && signed'({16'h0000, ioutMeas}) > ocLimit;

  always_comb
  begin
    c_d = c_q;
    c_d.uvMeta = uvDetect;
    c_d.uvSync = c_q.uvMeta;
    c_d.reqMeta = l_q.reqTgl;
    c_d.reqSync = c_q.reqMeta;
    c_d.reqSeen = c_q.reqSync;
    if (clearCmd)
    begin
      c_d.uvFlag = 1'b0;
      c_d.ocFlag = 1'b0;
    end
    // Set after clear so a fault in the clearing cycle is kept
    if (uvTrip)
      c_d.uvFlag = 1'b1;
    if (ocTrip)
      c_d.ocFlag = 1'b1;
    c_d.alertDrv = c_d.uvFlag || c_d.ocFlag;
    if (exec)
    begin
      c_d.ackTgl = ~c_q.ackTgl;
      if (l_q.cmd.write && l_q.cmd.code == CMD_OC_THRESH)
      begin
        c_d.thresh = l_q.cmd.data;
        c_d.threshSet = 1'b1;
      end
      case (l_q.cmd.code)
        CMD_UV_ACTION:   c_d.rspData = {8'h00, UV_ACTION_VAL};
        CMD_OC_THRESH:   c_d.rspData = threshRead;
        CMD_OC_ACTION:   c_d.rspData = {8'h00, OC_ACTION_VAL};
        CMD_STATUS_BYTE: c_d.rspData = {8'h00, statusByte};
        CMD_STATUS_WORD: c_d.rspData = statusWord;
        CMD_STATUS_VOUT: c_d.rspData = 16'(c_q.uvFlag) << SV_UV_BIT;
        CMD_STATUS_IOUT: c_d.rspData = 16'(c_q.ocFlag) << SI_OC_BIT;
        default:         c_d.rspData = 16'h0000;
      endcase
    end
    case (c_q.phase)
      PMBUV_RUN:
      begin
        if (uvTrip || ocTrip)
        begin
          c_d.phase = PMBUV_OFF;
          c_d.shutDown = 1'b1;
          c_d.delayCnt = '0;
        end
      end
      PMBUV_OFF:
      begin
        if (c_q.delayCnt == DLY_W'(RESTART_CNT - 1))
        begin
          c_d.phase = PMBUV_RUN;
          c_d.shutDown = 1'b0;
        end
        else
          c_d.delayCnt = c_q.delayCnt + 1'b1;
      end
      default:
      begin
        c_d.phase = PMBUV_RUN;
        c_d.shutDown = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      c_q <= '0;
    else
      c_q <= c_d;
  end

  // Link side: one command in flight, crossing by toggle handshake
  always_comb
  begin
    l_d = l_q;
    l_d.ackMeta = c_q.ackTgl;
    l_d.ackSync = l_q.ackMeta;
    l_d.ackSeen = l_q.ackSync;
    l_d.rspValid = 1'b0;
    if (cmdValid && !l_q.busy)
    begin
      l_d.cmd = cmdIn;
      l_d.reqTgl = ~l_q.reqTgl;
      l_d.busy = 1'b1;
    end
    // Core answer word is held still until the next request
    if (l_q.ackSync != l_q.ackSeen)
    begin
      l_d.busy = 1'b0;
      l_d.rspValid = 1'b1;
      l_d.rspData = c_q.rspData;
    end
  end

  always_ff @(posedge linkClk or negedge rstn)
  begin
    if (!rstn)
      l_q <= '0;
    else
      l_q <= l_d;
  end

  assign cmdReady = !l_q.busy;
  assign rspValid = l_q.rspValid;
  assign rspData = l_q.rspData;
  assign outputEnable = !c_q.shutDown;
  assign hostAlertOutO = 1'b0;
  assign hostAlertOutOe = c_q.alertDrv;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_uv_trip;
    uvTrip;
  endsequence
  sequence s_oc_trip;
    ocTrip;
  endsequence
  sequence s_read(logic [7:0] cmdCode);
    exec && l_q.cmd.code == cmdCode;
  endsequence

  property p_uv_other;
    s_uv_trip |=> statusByte[SB_OTHER_BIT];
  endproperty
  a_uv_other: assert property (p_uv_other)
    else $error("undervoltage did not set other bit");

  property p_uv_word;
    s_uv_trip |=> statusWord[SW_VOUT_BIT]
                  && statusWord[SB_OTHER_BIT];
  endproperty
  a_uv_word: assert property (p_uv_word)
    else $error("undervoltage did not set vout word bit");

  property p_uv_flag;
    s_uv_trip |=> c_q.uvFlag ##1 c_q.uvFlag || $past(clearCmd);
  endproperty
  a_uv_flag: assert property (p_uv_flag)
    else $error("undervoltage flag not set");

  property p_alert;
    (s_uv_trip or s_oc_trip) |=> hostAlertOutOe && !hostAlertOutO;
  endproperty
  a_alert: assert property (p_alert)
    else $error("alert not driven after fault");

  property p_shutdown;
    (s_uv_trip or s_oc_trip) |=> !outputEnable [*2];
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("output not shut down after fault");

  property p_restart;
    c_q.phase == PMBUV_OFF && c_q.delayCnt == DLY_W'(RESTART_CNT - 1)
      |=> outputEnable && c_q.phase == PMBUV_RUN;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart not taken at end of delay");

  property p_uv_action;
    s_read(CMD_UV_ACTION) |=> c_q.rspData == {8'h00, UV_ACTION_VAL};
  endproperty
  a_uv_action: assert property (p_uv_action)
    else $error("undervoltage action read wrong");

  property p_oc_action;
    s_read(CMD_OC_ACTION) |=> c_q.rspData == {8'h00, OC_ACTION_VAL};
  endproperty
  a_oc_action: assert property (p_oc_action)
    else $error("overcurrent action read wrong");

  property p_oc_status;
    s_oc_trip |=> statusByte[SB_OC_BIT] && statusWord[SW_IOUT_BIT]
                  && c_q.ocFlag;
  endproperty
  a_oc_status: assert property (p_oc_status)
    else $error("overcurrent status bits not set");

  property p_sticky;
    c_q.ocFlag && !clearCmd |=> c_q.ocFlag;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("overcurrent flag dropped without clear");

  property p_clear;
    clearCmd && !uvTrip && !ocTrip
      |=> !c_q.uvFlag && !c_q.ocFlag && !hostAlertOutOe;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear command left a fault flag or alert set");

  // Output must stay off for the whole delay, whatever the inputs do
  property p_off_hold;
    c_q.phase == PMBUV_OFF && c_q.delayCnt != DLY_W'(RESTART_CNT - 1)
      |=> !outputEnable;
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("output restarted before the delay ran out");

  property p_thresh_write;
    exec && l_q.cmd.write && l_q.cmd.code == CMD_OC_THRESH
      |=> c_q.thresh == $past(l_q.cmd.data) && c_q.threshSet;
  endproperty
  a_thresh_write: assert property (p_thresh_write)
    else $error("threshold write not stored");

endmodule

// ---- pmbuv_host_model.sv ----
// Host side of the command link: issues one command at a time
`timescale 1ns/10ps
module pmbuv_host_model
  import pmbuv_pkg::*;
(
  input  wire logic        linkClk,
  input  wire logic        rstn,
  input  wire logic        go,
  input  wire logic        hostWr,
  input  wire logic [7:0]  hostCode,
  input  wire logic [15:0] hostData,
  input  wire logic        cmdReady,
  input  wire logic        rspValid,
  input  wire logic [15:0] rspData,
  output logic             cmdValid,
  output pmbuv_cmd_t       cmdIn,
  output logic             done,
  output logic [15:0]      rdata
);
  logic waitRsp;

  // Released command word shows the inverse so stale data is never reused
  always_ff @(posedge linkClk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmdValid <= 1'b0;
      waitRsp  <= 1'b0;
      done     <= 1'b0;
      cmdIn    <= '0;
      rdata    <= 16'h0000;
    end
    else
    begin
      done <= 1'b0;
      if (cmdValid && cmdReady)
      begin
        cmdValid <= 1'b0;
        waitRsp  <= 1'b1;
        cmdIn    <= ~cmdIn;
      end
      else if (waitRsp && rspValid)
      begin
        waitRsp <= 1'b0;
        done    <= 1'b1;
        rdata   <= rspData;
      end
      else if (!cmdValid && !waitRsp && go && !done)
      begin
        cmdValid <= 1'b1;
        cmdIn    <= {hostWr, hostCode, hostData};
      end
    end
  end
endmodule

// ---- test_pmbuv_fault_ctrl.sv ----
// Self-checking bench for the fault handling block
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("FAIL %0t got %h exp %h", $time, a, e); end end
module test_pmbuv_fault_ctrl;
  import pmbuv_pkg::*;
  localparam int RST_N = 20;
  logic clk, linkClk, rstn, uvDetect, go, hostWr, done;
  logic [15:0] ioutMeas, maxCur, hostData, rdata, rspData, r;
  logic [7:0]  hostCode;
  logic        cmdValid, cmdReady, rspValid, outEn, alO, alOe, alertLine;
  pmbuv_cmd_t  cmdIn;
  int          failures, checks_done, cyc, n;
  logic [15:0] thr [2] = '{16'h0832, 16'hf92c};
  logic [15:0] lim [2] = '{16'd100, 16'd150};

  // Pull-up on the open-drain alert line
  assign alertLine = alOe ? alO : 1'b1;

  pmbuv_fault_ctrl #(.RESTART_CNT(RST_N)) dut (.clk(clk), .rstn(rstn),
    .linkClk(linkClk), .uvDetect(uvDetect), .ioutMeas(ioutMeas),
    .maxCurrentSetting(maxCur), .cmdValid(cmdValid), .cmdIn(cmdIn),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
    .outputEnable(outEn), .hostAlertOutO(alO), .hostAlertOutOe(alOe));

  pmbuv_host_model host (.linkClk(linkClk), .rstn(rstn), .go(go),
    .hostWr(hostWr), .hostCode(hostCode), .hostData(hostData),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
    .cmdValid(cmdValid), .cmdIn(cmdIn), .done(done), .rdata(rdata));

  initial begin clk = 0; forever #10 clk = ~clk; end
  initial begin linkClk = 0; #3; forever #6 linkClk = ~linkClk; end

  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Generous ceiling; the whole sequence takes a few hundred cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      $display("FAIL %0t timeout", $time);
      failures++;
      end_sim();
    end
  end

  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [15:0] d, output logic [15:0] q);
    int k;
    @(posedge linkClk);
    go <= 1'b1; hostWr <= w; hostCode <= c; hostData <= d;
    for (k = 0; k < 40 && done !== 1'b1; k++) @(posedge linkClk);
    go <= 1'b0;
    `CHK(done, 1'b1)
    q = rdata;
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] q;
    xfer(1'b0, c, 16'h0000, q);
    `CHK(q, e)
  endtask

  task automatic stat(input logic [15:0] b, w, v, i);
    rd(CMD_STATUS_BYTE, b);
    rd(CMD_STATUS_WORD, w);
    rd(CMD_STATUS_VOUT, v);
    rd(CMD_STATUS_IOUT, i);
  endtask

  // Waits for shutdown, removes the cause, times the off period
  task automatic fault_run();
    int k;
    for (k = 0; k < 20 && outEn !== 1'b0; k++) begin @(posedge clk); #1; end
    ioutMeas <= 16'h0000;
    uvDetect <= 1'b0;
    n = 0;
    while (outEn === 1'b0 && n < 100) begin @(posedge clk); #1; n++; end
    `CHK(n, RST_N)
    `CHK(alertLine, 1'b0)
  endtask

  task automatic oc_case(input logic [15:0] l);
    @(posedge clk) ioutMeas <= l;
    repeat (6) @(posedge clk);
    `CHK(outEn, 1'b1)
    @(posedge clk) ioutMeas <= l + 16'h0001;
    fault_run();
  endtask

  initial
  begin
    rstn = 0; uvDetect = 0; go = 0; hostWr = 0; hostCode = 8'h00;
    hostData = 16'h0000; ioutMeas = 16'h0000; maxCur = 16'd100;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge linkClk);
    `CHK(outEn, 1'b1)
    `CHK(alertLine, 1'b1)
    rd(CMD_UV_ACTION, 16'h00ba);
    xfer(1'b1, CMD_UV_ACTION, 16'h0045, r);
    rd(CMD_UV_ACTION, 16'h00ba);
    rd(CMD_OC_ACTION, 16'h00fa);
    xfer(1'b1, CMD_OC_ACTION, 16'h0012, r);
    rd(CMD_OC_ACTION, 16'h00fa);
    stat(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    rd(CMD_OC_THRESH, 16'h007d);
    oc_case(16'd125);
    stat(16'h0010, 16'h4010, 16'h0000, 16'h0080);
    xfer(1'b1, CMD_CLEAR_FAULTS, 16'h0000, r);
    stat(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    `CHK(alertLine, 1'b1)
    for (int t = 0; t < 2; t++)
    begin
      xfer(1'b1, CMD_OC_THRESH, thr[t], r);
      rd(CMD_OC_THRESH, thr[t]);
      oc_case(lim[t]);
      xfer(1'b1, CMD_CLEAR_FAULTS, 16'h0000, r);
    end
    @(posedge clk) uvDetect <= 1'b1;
    fault_run();
    stat(16'h0001, 16'h8001, 16'h0010, 16'h0000);
    xfer(1'b1, CMD_CLEAR_FAULTS, 16'h0000, r);
    rd(CMD_STATUS_BYTE, 16'h0000);
    end_sim();
  end
endmodule
